// [hw/sol_pkg.sv]
// Shared constants for the drive status output logic.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
package sol_pkg;
    localparam int unsigned WB_AW = 8;
    localparam int unsigned WB_DW = 32;
    localparam int unsigned OPT_W = 6;
    localparam int unsigned N_LOGIC = 6;
    localparam int unsigned N_GENERAL = 6;
    localparam int unsigned N_EVT = 6;
    localparam int unsigned SENS_W = 8;

    // Register byte offsets
    localparam logic [WB_AW-1:0] ADDR_CFG = 8'h00;
    localparam logic [WB_AW-1:0] ADDR_OVERHEAT_LEVEL = 8'h04;
    localparam logic [WB_AW-1:0] ADDR_LOW_CURRENT_LEVEL = 8'h08;
    localparam logic [WB_AW-1:0] ADDR_GENERAL_OUT = 8'h0C;
    localparam logic [WB_AW-1:0] ADDR_LOGIC_BASE = 8'h10;
    localparam logic [WB_AW-1:0] ADDR_STATUS = 8'h28;
    localparam logic [WB_AW-1:0] ADDR_IRQ_STATUS = 8'h2C;
    localparam logic [WB_AW-1:0] ADDR_IRQ_CLEAR = 8'h30;
    localparam logic [WB_AW-1:0] ADDR_IRQ_ENABLE = 8'h34;

    // Field positions
    localparam int unsigned CFG_FAN_LSB = 0;
    localparam int unsigned CFG_LCMODE_LSB = 2;
    localparam int unsigned LOGIC_A_LSB = 0;
    localparam int unsigned LOGIC_B_LSB = 8;
    localparam int unsigned LOGIC_OP_LSB = 16;

    // Reset values
    localparam logic [1:0] FAN_CTRL_RST = 2'h0;
    localparam logic [1:0] LC_MODE_RST = 2'h0;
    localparam logic [SENS_W-1:0] OVERHEAT_LEVEL_RST = 8'h5A;
    localparam logic [SENS_W-1:0] LOW_CURRENT_LEVEL_RST = 8'h00;

    // Option codes
    localparam logic [OPT_W-1:0] OPT_LOGIC_FIRST = 6'h21;
    localparam logic [OPT_W-1:0] OPT_CAP_LIFE = 6'h27;
    localparam logic [OPT_W-1:0] OPT_LOW_FAN = 6'h28;
    localparam logic [OPT_W-1:0] OPT_START_CONTACT = 6'h29;
    localparam logic [OPT_W-1:0] OPT_OVERHEAT = 6'h2A;
    localparam logic [OPT_W-1:0] OPT_LOW_CURRENT = 6'h2B;
    localparam logic [OPT_W-1:0] OPT_GENERAL_FIRST = 6'h2C;
    localparam logic [OPT_W-1:0] OPT_READY = 6'h32;

    // Operator, fan and monitoring mode codes
    localparam logic [1:0] OP_AND = 2'h0;
    localparam logic [1:0] OP_OR = 2'h1;
    localparam logic [1:0] OP_XOR = 2'h2;
    localparam logic [1:0] FAN_RUN_ONLY = 2'h1;
    localparam logic [1:0] LC_ALL_PHASES = 2'h0;
    localparam logic [1:0] LC_CONST_ONLY = 2'h1;

    // Thresholds: fan in percent, current in tenths of rated current
    localparam logic [SENS_W-1:0] FAN_LOW_PCT = 8'h4B;
    localparam logic [SENS_W-1:0] LOW_CURRENT_MAX = 8'h14;
    localparam logic [SENS_W-1:0] CAP_LIFE_END = 8'h00;

    // Interrupt event bits
    localparam int unsigned EV_CAP = 0;
    localparam int unsigned EV_FAN = 1;
    localparam int unsigned EV_HEAT = 2;
    localparam int unsigned EV_LOWCUR = 3;
    localparam int unsigned EV_NOTREADY = 4;
    localparam int unsigned EV_RUNCLASH = 5;
endpackage

// [hw/sol_logic_gate.sv]
// One configurable two-input logic output.
// Assumes the option vector is already registered by the caller.
`timescale 1ns/1ps
`default_nettype none
module sol_logic_gate
    import sol_pkg::*;
(
    input wire logic [63:0] optVec,
    input wire logic [sol_pkg::OPT_W-1:0] aSel,
    input wire logic [sol_pkg::OPT_W-1:0] bSel,
    input wire logic [1:0] opSel,
    output logic result
);
    logic opA;
    logic opB;

    assign opA = optVec[aSel];
    assign opB = optVec[bSel];

    always_comb begin
        case (opSel)
            OP_AND: result = opA & opB;
            OP_OR: result = opA | opB;
            OP_XOR: result = opA ^ opB;
            default: result = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// [hw/sol_low_current.sv]
// Low output current comparator with phase qualification.
// Assumes synchronised current and phase inputs.
`timescale 1ns/1ps
`default_nettype none
module sol_low_current
    import sol_pkg::*;
(
    input wire logic [sol_pkg::SENS_W-1:0] current,
    input wire logic [sol_pkg::SENS_W-1:0] level,
    input wire logic [1:0] mode,
    input wire logic phaseAccel,
    input wire logic phaseDecel,
    input wire logic phaseConst,
    output logic result
);
    logic phaseOk;

    always_comb begin
        case (mode)
            LC_ALL_PHASES: phaseOk = phaseAccel | phaseDecel | phaseConst;
            LC_CONST_ONLY: phaseOk = phaseConst;
            default: phaseOk = 1'b0;
        endcase
    end

    assign result = phaseOk && (current < level);
endmodule
`default_nettype wire

// [hw/sol_status_logic.sv]
// Drive status output logic: selectable status signals with a Wishbone register file.
// Assumes all sensor and command inputs come from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module sol_status_logic
    import sol_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [sol_pkg::WB_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [sol_pkg::WB_DW-1:0] wb_dat_i,
    output logic [sol_pkg::WB_DW-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq,
    input wire logic [63:0] extOptions,
    input wire logic runForwardIn,
    input wire logic runReverseIn,
    input wire logic mainPowerOk,
    input wire logic driveTripped,
    input wire logic fanRunning,
    input wire logic phaseAccel,
    input wire logic phaseDecel,
    input wire logic phaseConst,
    input wire logic [sol_pkg::SENS_W-1:0] capLifePct,
    input wire logic [sol_pkg::SENS_W-1:0] fanSpeedPct,
    input wire logic [sol_pkg::SENS_W-1:0] heatsinkTempC,
    input wire logic [sol_pkg::SENS_W-1:0] outputCurrent,
    output logic [sol_pkg::N_LOGIC-1:0] logicOutput,
    output logic capacitorLifeWarning,
    output logic lowFanSpeedWarning,
    output logic startingContactOutput,
    output logic heatsinkOverheatWarning,
    output logic lowCurrentOutput,
    output logic [sol_pkg::N_GENERAL-1:0] generalOutput,
    output logic driveReadyOutput,
    output logic motorRunEnable
);
    localparam int unsigned SYNC_W = 9 + 4 * SENS_W + 64;

    // Two-stage synchroniser on every sensor and command input; the Wishbone inputs are not synchronised
    logic [SYNC_W-1:0] syncMeta_q;
    logic [SYNC_W-1:0] syncStable_q;
    logic [SYNC_W-1:0] pinBus;

    assign pinBus = {extOptions, runForwardIn, runReverseIn, mainPowerOk, driveTripped, fanRunning,
                     phaseAccel, phaseDecel, phaseConst, 1'b0, capLifePct, fanSpeedPct,
                     heatsinkTempC, outputCurrent};

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            syncMeta_q <= '0;
            syncStable_q <= '0;
        end else begin
            syncMeta_q <= pinBus;
            syncStable_q <= syncMeta_q;
        end
    end

    logic [63:0] extOpt;
    logic fwdS;
    logic revS;
    logic powerS;
    logic tripS;
    logic fanRunS;
    logic accelS;
    logic decelS;
    logic constS;
    logic [SENS_W-1:0] capS;
    logic [SENS_W-1:0] fanS;
    logic [SENS_W-1:0] tempS;
    logic [SENS_W-1:0] curS;
    logic unusedSpare;

    assign {extOpt, fwdS, revS, powerS, tripS, fanRunS, accelS, decelS, constS, unusedSpare,
            capS, fanS, tempS, curS} = syncStable_q;

    // Software-visible settings
    logic [1:0] fanCtrl_q;
    logic [1:0] lcMode_q;
    logic [SENS_W-1:0] heatLevel_q;
    logic [SENS_W-1:0] lcLevel_q;
    logic [N_GENERAL-1:0] generalReg_q;
    logic [OPT_W-1:0] srcA_q [N_LOGIC];
    logic [OPT_W-1:0] srcB_q [N_LOGIC];
    logic [1:0] oper_q [N_LOGIC];
    logic [N_EVT-1:0] irqStatus_q;
    logic [N_EVT-1:0] irqEnable_q;
    logic [N_EVT-1:0] irqStatus_d;

    // Bus handshake: data is latched with ack, writes land on the edge that sees ack
    logic busReq;
    logic wrCommit;
    logic [WB_DW-1:0] wrMask;
    logic [WB_DW-1:0] rdData;
    logic [N_EVT-1:0] irqClear;
    logic [N_EVT-1:0] events;

    assign busReq = wb_cyc_i & wb_stb_i;
    assign wrCommit = busReq & wb_we_i & wb_ack_o;
    assign wrMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    function automatic logic [WB_DW-1:0] merge(input logic [WB_DW-1:0] oldV, input logic [WB_DW-1:0] newV,
                                               input logic [WB_DW-1:0] mask);
        merge = (oldV & ~mask) | (newV & mask);
    endfunction

    logic [WB_DW-1:0] cfgWord;
    logic [WB_DW-1:0] cfgNew;
    logic [WB_DW-1:0] lcNew;
    logic [WB_DW-1:0] heatNew;
    logic [WB_DW-1:0] genNew;
    logic [WB_DW-1:0] lcWord;
    logic [WB_DW-1:0] irqEnNew;

    assign cfgWord = {28'h0000000, lcMode_q, fanCtrl_q};
    assign cfgNew = merge(cfgWord, wb_dat_i, wrMask);
    assign heatNew = merge({24'h000000, heatLevel_q}, wb_dat_i, wrMask);
    assign lcWord = merge({24'h000000, lcLevel_q}, wb_dat_i, wrMask);
    assign lcNew = (lcWord[SENS_W-1:0] > LOW_CURRENT_MAX) ? {24'h000000, LOW_CURRENT_MAX} : lcWord;
    assign genNew = merge({26'h0000000, generalReg_q}, wb_dat_i, wrMask);
    assign irqEnNew = merge({26'h0000000, irqEnable_q}, wb_dat_i, wrMask);
    assign irqClear = (wrCommit && wb_adr_i == ADDR_IRQ_CLEAR) ? wb_dat_i[N_EVT-1:0] : '0;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fanCtrl_q <= FAN_CTRL_RST;
            lcMode_q <= LC_MODE_RST;
            heatLevel_q <= OVERHEAT_LEVEL_RST;
            lcLevel_q <= LOW_CURRENT_LEVEL_RST;
            generalReg_q <= '0;
            irqEnable_q <= '0;
        end else if (wrCommit) begin
            case (wb_adr_i)
                ADDR_CFG: begin
                    fanCtrl_q <= cfgNew[CFG_FAN_LSB +: 2];
                    lcMode_q <= cfgNew[CFG_LCMODE_LSB +: 2];
                end
                ADDR_OVERHEAT_LEVEL: heatLevel_q <= heatNew[SENS_W-1:0];
                ADDR_LOW_CURRENT_LEVEL: lcLevel_q <= lcNew[SENS_W-1:0];
                ADDR_GENERAL_OUT: generalReg_q <= genNew[N_GENERAL-1:0];
                ADDR_IRQ_ENABLE: irqEnable_q <= irqEnNew[N_EVT-1:0];
                default: ;
            endcase
        end
    end

    // One settings triplet per logic output, at consecutive words
    genvar gi;
    generate
        for (gi = 0; gi < N_LOGIC; gi++) begin : gTriplet
            localparam logic [WB_AW-1:0] ADDR_T = ADDR_LOGIC_BASE + WB_AW'(4 * gi);
            logic [WB_DW-1:0] tripWord;
            logic [WB_DW-1:0] tripNew;
            assign tripWord = {14'h0000, oper_q[gi], 2'h0, srcB_q[gi], 2'h0, srcA_q[gi]};
            assign tripNew = merge(tripWord, wb_dat_i, wrMask);
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    srcA_q[gi] <= '0;
                    srcB_q[gi] <= '0;
                    oper_q[gi] <= OP_AND;
                end else if (wrCommit && wb_adr_i == ADDR_T) begin
                    srcA_q[gi] <= tripNew[LOGIC_A_LSB +: OPT_W];
                    srcB_q[gi] <= tripNew[LOGIC_B_LSB +: OPT_W];
                    oper_q[gi] <= tripNew[LOGIC_OP_LSB +: 2];
                end
            end
        end
    endgenerate

    // Status conditions, evaluated from the synchronised inputs
    logic capWarn_d;
    logic fanWarn_d;
    logic start_d;
    logic heat_d;
    logic lowCur_d;
    logic ready_d;
    logic runClash;
    logic [N_LOGIC-1:0] logic_d;

    assign capWarn_d = (capS <= CAP_LIFE_END);
    assign fanWarn_d = (fanS <= FAN_LOW_PCT) && !(fanCtrl_q == FAN_RUN_ONLY && !fanRunS);
    assign runClash = fwdS & revS;
    assign start_d = (fwdS | revS) & ~runClash;
    assign heat_d = (tempS > heatLevel_q);
    assign ready_d = powerS & ~tripS;

    sol_low_current uLowCur (
        .current(curS),
        .level(lcLevel_q),
        .mode(lcMode_q),
        .phaseAccel(accelS),
        .phaseDecel(decelS),
        .phaseConst(constS),
        .result(lowCur_d)
    );

    // Operand vector of registered outputs; using last cycle's values keeps loops between outputs safe
    logic [63:0] optVec;
    always_comb begin
        optVec = extOpt;
        optVec[OPT_LOGIC_FIRST +: N_LOGIC] = logicOutput;
        optVec[OPT_CAP_LIFE] = capacitorLifeWarning;
        optVec[OPT_LOW_FAN] = lowFanSpeedWarning;
        optVec[OPT_START_CONTACT] = startingContactOutput;
        optVec[OPT_OVERHEAT] = heatsinkOverheatWarning;
        optVec[OPT_LOW_CURRENT] = lowCurrentOutput;
        optVec[OPT_GENERAL_FIRST +: N_GENERAL] = generalOutput;
        optVec[OPT_READY] = driveReadyOutput;
    end

    generate
        for (gi = 0; gi < N_LOGIC; gi++) begin : gLogic
            sol_logic_gate uGate (
                .optVec(optVec),
                .aSel(srcA_q[gi]),
                .bSel(srcB_q[gi]),
                .opSel(oper_q[gi]),
                .result(logic_d[gi])
            );
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            logicOutput <= '0;
            capacitorLifeWarning <= 1'b0;
            lowFanSpeedWarning <= 1'b0;
            startingContactOutput <= 1'b0;
            heatsinkOverheatWarning <= 1'b0;
            lowCurrentOutput <= 1'b0;
            generalOutput <= '0;
            driveReadyOutput <= 1'b0;
            motorRunEnable <= 1'b0;
        end else begin
            logicOutput <= logic_d;
            capacitorLifeWarning <= capWarn_d;
            lowFanSpeedWarning <= fanWarn_d;
            startingContactOutput <= start_d;
            heatsinkOverheatWarning <= heat_d;
            lowCurrentOutput <= lowCur_d;
            generalOutput <= generalReg_q;
            driveReadyOutput <= ready_d;
            motorRunEnable <= ready_d & start_d;
        end
    end

    // Interrupts: set wins over a clear in the same cycle
    assign events[EV_CAP] = capWarn_d & ~capacitorLifeWarning;
    assign events[EV_FAN] = fanWarn_d & ~lowFanSpeedWarning;
    assign events[EV_HEAT] = heat_d & ~heatsinkOverheatWarning;
    assign events[EV_LOWCUR] = lowCur_d & ~lowCurrentOutput;
    assign events[EV_NOTREADY] = ~ready_d & driveReadyOutput;
    assign events[EV_RUNCLASH] = runClash;
    assign irqStatus_d = (irqStatus_q & ~irqClear) | events;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irqStatus_q <= '0;
            irq <= 1'b0;
        end else begin
            irqStatus_q <= irqStatus_d;
            irq <= |(irqStatus_d & irqEnable_q);
        end
    end

    // Read mux; unmapped addresses read zero and are still acknowledged
    always_comb begin
        rdData = '0;
        case (wb_adr_i)
            ADDR_CFG: rdData = cfgWord;
            ADDR_OVERHEAT_LEVEL: rdData[SENS_W-1:0] = heatLevel_q;
            ADDR_LOW_CURRENT_LEVEL: rdData[SENS_W-1:0] = lcLevel_q;
            ADDR_GENERAL_OUT: rdData[N_GENERAL-1:0] = generalReg_q;
            ADDR_STATUS: rdData[17:0] = optVec[OPT_READY:OPT_LOGIC_FIRST];
            ADDR_IRQ_STATUS: rdData[N_EVT-1:0] = irqStatus_q;
            ADDR_IRQ_ENABLE: rdData[N_EVT-1:0] = irqEnable_q;
            default: begin
                for (int k = 0; k < N_LOGIC; k++) begin
                    if (wb_adr_i == ADDR_LOGIC_BASE + WB_AW'(4 * k)) begin
                        rdData = {14'h0000, oper_q[k], 2'h0, srcB_q[k], 2'h0, srcA_q[k]};
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= busReq & ~wb_ack_o;
            if (busReq && !wb_ack_o && !wb_we_i) begin
                wb_dat_o <= rdData;
            end
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    conflict_stops_run_a: assert property (fwdS && revS |=> !startingContactOutput && !motorRunEnable)
        else $error("Run clash did not stop the motor");
    contact_follows_run_a: assert property ((fwdS ^ revS) |=> startingContactOutput)
        else $error("Starting contact missing");
    ready_needs_power_a: assert property (!powerS |=> !driveReadyOutput ##0 !motorRunEnable)
        else $error("Ready while main power absent");
    refuse_not_ready_a: assert property (motorRunEnable |-> driveReadyOutput)
        else $error("Run enabled while not ready");
    fan_masked_a: assert property (fanCtrl_q == FAN_RUN_ONLY && !fanRunS && $stable(fanCtrl_q)
                                   |=> !lowFanSpeedWarning)
        else $error("Fan warning while fan stopped on purpose");
    fan_threshold_a: assert property (fanS <= FAN_LOW_PCT && fanRunS |=> lowFanSpeedWarning)
        else $error("Fan warning missed");
    overheat_cmp_a: assert property (tempS > heatLevel_q && $stable(heatLevel_q)
                                     |=> heatsinkOverheatWarning)
        else $error("Overheat warning missed");
    cap_life_a: assert property (capS == CAP_LIFE_END |=> capacitorLifeWarning)
        else $error("Capacitor warning missed");
    lc_const_only_a: assert property (lcMode_q == LC_CONST_ONLY && !constS && $stable(lcMode_q)
                                      |=> !lowCurrentOutput)
        else $error("Low current outside constant speed");
    lc_level_max_a: assert property (lcLevel_q <= LOW_CURRENT_MAX)
        else $error("Low current level out of range");
    xor_logic_a: assert property (oper_q[0] == OP_XOR && $stable(oper_q[0])
                                  |=> logicOutput[0] == ($past(optVec[srcA_q[0]]) ^ $past(optVec[srcB_q[0]])))
        else $error("Logic output one wrong");
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("Ack held longer than one cycle");

    clash_seen_c: cover property (fwdS && revS ##1 !startingContactOutput);
    logic_toggle_c: cover property ($rose(logicOutput[5]));
    low_current_c: cover property ($rose(lowCurrentOutput));
    irq_raised_c: cover property ($rose(irq));
endmodule
`default_nettype wire

// [tb/sol_machine_model.sv]
// Machine wired to the status terminals: counts starting contact closures.
// Assumes registered, glitch-free outputs from the drive.
`timescale 1ns/1ps
`default_nettype none
module sol_machine_model (
    input wire logic clk_sys,
    input wire logic startingContactOutput,
    output logic [7:0] closures
);
    logic prev = 1'b0;
    logic [7:0] count = 8'h00;
    assign closures = count;
    // A relay only sees closures, so a rising edge is one start
    always @(posedge clk_sys) begin
        if (startingContactOutput && !prev) count <= count + 8'h01;
        prev <= startingContactOutput;
    end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the drive status output logic.
// Assumes one 50 MHz clock and levels that settle within six cycles.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sol_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o, irq, driveReadyOutput, motorRunEnable;
    logic [63:0] extOptions = 64'h0;
    logic runForwardIn = 1'b0, runReverseIn = 1'b0, mainPowerOk = 1'b1, driveTripped = 1'b0;
    logic fanRunning = 1'b1, phaseAccel = 1'b0, phaseDecel = 1'b0, phaseConst = 1'b0;
    logic [7:0] capLifePct = 8'h50, fanSpeedPct = 8'h64, heatsinkTempC = 8'h20, outputCurrent = 8'h0A;
    logic [5:0] logicOutput, generalOutput, gen = 6'h00;
    logic capacitorLifeWarning, lowFanSpeedWarning, startingContactOutput, heatsinkOverheatWarning;
    logic lowCurrentOutput, irqExp = 1'b0, sampleReq = 1'b0;
    logic [7:0] closures, lcLvl = 8'h00;
    logic [1:0] fanCtl = 2'h0, lcMode = 2'h0;
    logic [5:0] aSel[6], bSel[6];
    logic [1:0] opSel[6];
    logic [19:0] expQ[$];
    logic [31:0] rdQ[$];
    int err_count = 0;
    int checks_done = 0;

    sol_status_logic uut (
        .clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .irq, .extOptions, .runForwardIn, .runReverseIn, .mainPowerOk, .driveTripped,
        .fanRunning, .phaseAccel, .phaseDecel, .phaseConst, .capLifePct, .fanSpeedPct, .heatsinkTempC,
        .outputCurrent, .logicOutput, .capacitorLifeWarning, .lowFanSpeedWarning, .startingContactOutput,
        .heatsinkOverheatWarning, .lowCurrentOutput, .generalOutput, .driveReadyOutput, .motorRunEnable
    );
    sol_machine_model model (
        .clk_sys,
        .startingContactOutput,
        .closures
    );

    initial begin
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (e !== s) begin
            $display("unexpected %s expected %h seen %h", nm, e, s);
            err_count++;
        end
    endtask

    // Expected levels of every status output from the bench's own input state
    function automatic logic [19:0] predict();
        logic [5:0] lg;
        logic [63:0] ov;
        logic ph, cw, fw, st, ht, lc, rd;
        ph = (lcMode == LC_CONST_ONLY) ? phaseConst : (phaseAccel | phaseDecel | phaseConst);
        cw = capLifePct == CAP_LIFE_END;
        fw = fanSpeedPct <= FAN_LOW_PCT && !(fanCtl == FAN_RUN_ONLY && !fanRunning);
        st = runForwardIn ^ runReverseIn;
        ht = heatsinkTempC > OVERHEAT_LEVEL_RST;
        lc = outputCurrent < lcLvl && ph;
        rd = mainPowerOk && !driveTripped;
        // Internal options as operands; logic-on-logic sources are not used here
        ov = extOptions;
        ov[OPT_CAP_LIFE +: 5] = {lc, ht, st, fw, cw};
        ov[OPT_GENERAL_FIRST +: 6] = gen;
        ov[OPT_READY] = rd;
        for (int k = 0; k < 6; k++) begin
            case (opSel[k])
                OP_AND: lg[k] = ov[aSel[k]] & ov[bSel[k]];
                OP_OR: lg[k] = ov[aSel[k]] | ov[bSel[k]];
                default: lg[k] = ov[aSel[k]] ^ ov[bSel[k]];
            endcase
        end
        return {irqExp, lg, cw, fw, st, ht, lc, gen, rd, rd && st};
    endfunction

    // Results are taken off the queues only when the design shows them
    always @(posedge clk_sys) begin
        if (sampleReq) cmp("outputs", {12'h0, expQ.pop_front()}, {12'h0, irq, logicOutput,
            capacitorLifeWarning, lowFanSpeedWarning, startingContactOutput, heatsinkOverheatWarning,
            lowCurrentOutput, generalOutput, driveReadyOutput, motorRunEnable});
        if (wb_ack_o && !wb_we_i) cmp("read data", rdQ.size() ? rdQ.pop_front() : 32'hDEAD_BEEF, wb_dat_o);
    end

    task automatic settle_check();
        repeat (6) @(posedge clk_sys);
        expQ.push_back(predict());
        sampleReq <= 1'b1;
        @(posedge clk_sys);
        sampleReq <= 1'b0;
    endtask

    // Classic single cycle; a read queues its expected data
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        if (!we) rdQ.push_back(d);
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (wb_ack_o !== 1'b1) begin
            err_count++;
            finish_test();
        end else begin
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            @(posedge clk_sys);
        end
    endtask

    initial begin
        repeat (100000) @(posedge clk_sys);
        err_count++;
        finish_test();
    end

    initial begin
        void'($urandom(32'h0E02));
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        wb(0, ADDR_CFG, 32'h0);
        wb(0, ADDR_OVERHEAT_LEVEL, {24'h0, OVERHEAT_LEVEL_RST});
        wb(0, 8'h3C, 32'h0);
        for (int k = 0; k < 6; k++) begin
            aSel[k] = 6'(k + 1);
            bSel[k] = 6'(k + 10);
            opSel[k] = 2'((k + 2) % 3);
            wb(1, ADDR_LOGIC_BASE + 8'(4 * k), {14'h0, opSel[k], 2'h0, bSel[k], 2'h0, aSel[k]});
        end
        repeat (12) begin
            extOptions <= {$urandom, $urandom};
            settle_check();
        end
        fanSpeedPct <= FAN_LOW_PCT;
        settle_check();
        fanSpeedPct <= FAN_LOW_PCT + 8'h01;
        settle_check();
        {fanCtl, lcMode, lcLvl} = {FAN_RUN_ONLY, LC_CONST_ONLY, LOW_CURRENT_MAX};
        wb(1, ADDR_CFG, {28'h0, lcMode, fanCtl});
        wb(1, ADDR_LOW_CURRENT_LEVEL, 32'h0000_00FF);
        wb(0, ADDR_LOW_CURRENT_LEVEL, {24'h0, LOW_CURRENT_MAX});
        fanSpeedPct <= 8'h10;
        fanRunning <= 1'b0;
        outputCurrent <= 8'h13;
        phaseAccel <= 1'b1;
        settle_check();
        fanRunning <= 1'b1;
        phaseConst <= 1'b1;
        settle_check();
        outputCurrent <= 8'h14;
        settle_check();
        {fanCtl, lcMode} = {2'h0, LC_ALL_PHASES};
        wb(1, ADDR_CFG, 32'h0);
        phaseConst <= 1'b0;
        outputCurrent <= 8'h00;
        settle_check();
        wb(1, ADDR_IRQ_CLEAR, 32'h3F);
        wb(1, ADDR_IRQ_ENABLE, 32'h1 << EV_HEAT);
        heatsinkTempC <= OVERHEAT_LEVEL_RST;
        settle_check();
        heatsinkTempC <= OVERHEAT_LEVEL_RST + 8'h01;
        irqExp = 1'b1;
        settle_check();
        wb(0, ADDR_IRQ_STATUS, 32'h1 << EV_HEAT);
        wb(1, ADDR_IRQ_ENABLE, 32'h0);
        irqExp = 1'b0;
        settle_check();
        wb(1, ADDR_IRQ_ENABLE, 32'h1 << EV_HEAT);
        wb(1, ADDR_IRQ_CLEAR, 32'h1 << EV_HEAT);
        settle_check();
        aSel[5] = OPT_READY;
        bSel[5] = OPT_START_CONTACT;
        opSel[5] = OP_AND;
        wb(1, ADDR_LOGIC_BASE + 8'h14, {14'h0, opSel[5], 2'h0, bSel[5], 2'h0, aSel[5]});
        capLifePct <= CAP_LIFE_END;
        settle_check();
        runForwardIn <= 1'b1;
        settle_check();
        runReverseIn <= 1'b1;
        settle_check();
        runForwardIn <= 1'b0;
        settle_check();
        runReverseIn <= 1'b0;
        mainPowerOk <= 1'b0;
        settle_check();
        mainPowerOk <= 1'b1;
        driveTripped <= 1'b1;
        settle_check();
        driveTripped <= 1'b0;
        gen = 6'($urandom);
        wb(1, ADDR_GENERAL_OUT, {26'h0, gen});
        settle_check();
        cmp("closures", 32'h2, {24'h0, closures});
        finish_test();
    end
endmodule
`default_nettype wire
